// *** logic/aims_core.sv ***
// Purpose: analog position and speed control front end with APB registers
// Assumes: on-chip converter delivers samples on CLOCK; power and fault are pins
// Notes: step generation lives outside; STEP_DONE reports each finished step
`timescale 1ns/10ps
`include "aims_params.svh"
module aims_core
	import aims_pkg::*;
(
	input  wire logic               CLOCK,           // 50 MHz system clock
	input  wire logic               RESET_N,         // synchronous reset, active low
	input  wire logic               PSEL,            // apb select
	input  wire logic               PENABLE,         // apb access phase
	input  wire logic               PWRITE,          // apb direction
	input  wire logic [7:0]         PADDR,           // apb byte address
	input  wire logic [31:0]        PWDATA,          // apb write data
	output logic      [31:0]        PRDATA,          // apb read data
	output logic                    PREADY,          // apb ready
	output logic                    PSLVERR,         // apb error
	input  wire logic [`ADC_W-1:0]  ANALOG_INPUT_PIN_CODE,  // converted input
	input  wire logic               ANALOG_INPUT_PIN_VALID, // sample strobe
	input  wire logic               MOTOR_POWER,     // motor supply present, pin
	input  wire logic               DRIVER_FAULT,    // fault condition, pin
	input  wire logic               STEP_DONE,       // one step finished
	input  wire logic               SCL_I,           // scl pin level, unused here
	output logic                    SCL_O,           // scl drive value
	output logic                    SCL_OE,          // scl drive enable
	output logic                    MOTOR_ENERGIZE,  // driver enable
	output logic                    MOTOR_DIR,       // physical direction
	output logic                    MOTOR_MOVE,      // step request level
	output logic signed [`TGT_W-1:0] MOTOR_TARGET,   // position or velocity
	output logic                    MOTOR_MICRO,     // target unit is microsteps
	output logic                    IRQ              // level interrupt
);
	core_t            q;
	core_t            d;
	scale_cfg_t       cfg;
	scl_state_t       scl;
	logic [1:0]       pin_s;
	logic             pwr_s;
	logic             err_s;
	logic             setup;
	logic             wr;
	logic             rd;
	logic             resume;
	logic             analog;
	logic [`EV_W-1:0] ev;

	// pins cross into the clock domain
	aims_sync #(
		.W (2)
	) u_sync (
		.clock   (CLOCK),
		.reset_n (RESET_N),
		.async_i ({MOTOR_POWER, DRIVER_FAULT}),
		.sync_o  (pin_s)
	);
	assign pwr_s = pin_s[1];
	assign err_s = pin_s[0];

	// calibration and scaling of the sampled input
	assign cfg = q.cfg;
	aims_scaler u_scaler (
		.clock   (CLOCK),
		.reset_n (RESET_N),
		.cfg     (cfg),
		.sample  (ANALOG_INPUT_PIN_CODE),
		.smp_vld (ANALOG_INPUT_PIN_VALID),
		.res     (scl)
	);

	// bus phase decode
	assign setup  = PSEL && !PENABLE;
	assign wr     = PSEL && PENABLE && PWRITE;
	assign rd     = PSEL && PENABLE && !PWRITE;
	assign resume = wr && !q.slverr && (PADDR == `OFF_CTRL) && PWDATA[`CTRL_RESUME];
	assign analog = (q.mode == MODE_APOS) || (q.mode == MODE_ASPD);

	// next state: bus registers, events, sequencer, motor outputs
	always_comb begin
		mode_t new_mode;
		new_mode = mode_t'(PWDATA[`CTRL_MODE_LSB +: 2]);
		d = q;
		ev = '0;
		// setup phase: latch read data and the error answer
		if (setup) begin
			d.slverr = 1'b0;
			d.rdata  = '0;
			case (PADDR)
				`OFF_CTRL: begin
					d.rdata[`CTRL_MODE_LSB +: 2] = q.mode;
					d.rdata[`CTRL_NOSAFE]  = q.no_safe;
					d.rdata[`CTRL_INV_IN]  = q.cfg.inv_in;
					d.rdata[`CTRL_INV_MOT] = q.inv_mot;
					d.rdata[`CTRL_MICRO]   = q.micro;
				end
				`OFF_IN_MAX:   d.rdata[`ADC_W-1:0] = q.cfg.in_max;
				`OFF_NEU_MAX:  d.rdata[`ADC_W-1:0] = q.cfg.in_neu_max;
				`OFF_NEU_MIN:  d.rdata[`ADC_W-1:0] = q.cfg.in_neu_min;
				`OFF_IN_MIN:   d.rdata[`ADC_W-1:0] = q.cfg.in_min;
				`OFF_TGT_MAX: begin
					d.rdata = q.cfg.tgt_max;
					d.slverr = PWRITE && PWDATA[31];
				end
				`OFF_TGT_MIN: begin
					d.rdata = q.cfg.tgt_min;
					d.slverr = PWRITE && !PWDATA[31] && (PWDATA != '0);
				end
				`OFF_DEGREE:   d.rdata[1:0] = q.cfg.degree;
				`OFF_STATUS:   d.rdata[`EV_W-1:0] = q.status;
				`OFF_MASK:     d.rdata[`EV_W-1:0] = q.mask;
				`OFF_STATE:    d.rdata[6:0] = {q.known, q.ssv, q.energize, q.move, q.run};
				`OFF_TARGET:   d.rdata = q.tgt_out;
				`OFF_POSITION: d.rdata = q.pos;
				default:       d.slverr = 1'b1;
			endcase
		end
		// access phase: a write takes effect unless refused
		if (wr && !q.slverr) begin
			case (PADDR)
				`OFF_CTRL: begin
					d.mode        = new_mode;
					d.no_safe     = PWDATA[`CTRL_NOSAFE];
					d.cfg.inv_in  = PWDATA[`CTRL_INV_IN];
					d.inv_mot     = PWDATA[`CTRL_INV_MOT];
					d.micro       = PWDATA[`CTRL_MICRO];
				end
				`OFF_IN_MAX:  d.cfg.in_max     = PWDATA[`ADC_W-1:0];
				`OFF_NEU_MAX: d.cfg.in_neu_max = PWDATA[`ADC_W-1:0];
				`OFF_NEU_MIN: d.cfg.in_neu_min = PWDATA[`ADC_W-1:0];
				`OFF_IN_MIN:  d.cfg.in_min     = PWDATA[`ADC_W-1:0];
				`OFF_TGT_MAX: d.cfg.tgt_max    = PWDATA;
				`OFF_TGT_MIN: d.cfg.tgt_min    = PWDATA;
				`OFF_DEGREE:  d.cfg.degree     = PWDATA[1:0];
				`OFF_MASK:    d.mask           = PWDATA[`EV_W-1:0];
				default: ;
			endcase
		end
		// sequencer
		case (q.run)
			ST_IDLE: begin
				if (analog && !err_s) begin
					d.run = q.known ? ST_WAIT : ST_LEARN;
				end
			end
			ST_LEARN: begin
				// no position feedback: assume the motor sits where the input points
				if (scl.valid) begin
					if (q.mode == MODE_APOS) begin
						d.pos = scl.target;
					end
					d.known = 1'b1;
					d.run = ST_WAIT;
					ev[`EV_LEARN] = 1'b1;
				end
			end
			ST_WAIT: begin
				if (resume && pwr_s) begin
					ev[`EV_RESUME] = 1'b1;
					if ((q.mode == MODE_ASPD) && !q.no_safe) begin
						d.run = ST_NEUTRAL;
						ev[`EV_SSV] = 1'b1;
					end else begin
						d.run = ST_RUN;
					end
				end
			end
			ST_NEUTRAL: begin
				if (scl.valid && scl.neutral) begin
					d.run = ST_RUN;
				end
			end
			ST_RUN: begin
				if (STEP_DONE) begin
					d.pos = q.dir_log ? (q.pos + 32'sh00000001) : (q.pos - 32'sh00000001);
				end
			end
			default: d.run = ST_IDLE;
		endcase
		// losing motor power while running or waiting for neutral means losing the position too
		if (!pwr_s && ((q.run == ST_RUN) || (q.run == ST_NEUTRAL))) begin
			d.run = ST_LEARN;
			d.known = 1'b0;
		end
		// a fault holds the block idle and forgets the position
		if (err_s) begin
			d.run = ST_IDLE;
			d.known = 1'b0;
		end else if (q.err_prev && analog) begin
			d.run = ST_LEARN;
		end
		ev[`EV_ERR] = err_s && !q.err_prev;
		d.err_prev = err_s;
		// a mode change or leaving analog control restarts from idle
		if (!analog || (wr && !q.slverr && (PADDR == `OFF_CTRL) && (new_mode != q.mode))) begin
			d.run = ST_IDLE;
			d.known = 1'b0;
		end
		// motor outputs follow the sequencer state
		d.energize = (d.run == ST_RUN);
		d.ssv      = (d.run == ST_NEUTRAL);
		d.tgt_out  = scl.target;
		if (d.mode == MODE_APOS) begin
			d.dir_log = d.tgt_out > d.pos;
			d.move    = d.energize && (d.tgt_out != d.pos);
		end else begin
			d.dir_log = !d.tgt_out[`TGT_W-1];
			d.move    = d.energize && (d.tgt_out != '0);
		end
		d.dir_phys = d.dir_log ^ d.inv_mot;
		// sticky events: a new event wins over the read that clears
		d.status = ((rd && (PADDR == `OFF_STATUS)) ? '0 : q.status) | ev;
	end

	// state register with documented defaults
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			q <= '0;
			q.cfg.in_max     <= `RST_IN_MAX;
			q.cfg.in_neu_max <= `RST_NEU_MAX;
			q.cfg.in_neu_min <= `RST_NEU_MIN;
			q.cfg.in_min     <= `RST_IN_MIN;
			q.cfg.tgt_max    <= `RST_TGT_MAX;
			q.cfg.tgt_min    <= `RST_TGT_MIN;
			q.cfg.degree     <= `RST_DEGREE;
		end else begin
			q <= d;
		end
	end

	// port drive
	assign PRDATA         = q.rdata;
	assign PREADY         = PSEL && PENABLE;
	assign PSLVERR        = PSEL && PENABLE && q.slverr;
	assign SCL_O          = 1'b1;
	assign SCL_OE         = analog;
	assign MOTOR_ENERGIZE = q.energize;
	assign MOTOR_DIR      = q.dir_phys;
	assign MOTOR_MOVE     = q.move;
	assign MOTOR_TARGET   = q.tgt_out;
	assign MOTOR_MICRO    = q.micro;
	assign IRQ            = |(q.status & q.mask);

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	property p_scl_power;
		(wr && (PADDR == `OFF_CTRL) && !q.slverr && (PWDATA[`CTRL_MODE_LSB +: 2] == MODE_APOS))
			|=> SCL_OE && SCL_O;
	endproperty
	a_scl_power: assert property (p_scl_power) else $error("scl not driven in analog mode");

	property p_learn_pos;
		(q.run == ST_LEARN && scl.valid && q.mode == MODE_APOS && !err_s && pwr_s)
			|=> (q.pos == $past(scl.target)) && q.known;
	endproperty
	a_learn_pos: assert property (p_learn_pos) else $error("position not learned from input");

	property p_relearn;
		($past(err_s) && !err_s && analog && !wr) |-> ##1 (q.run == ST_LEARN);
	endproperty
	a_relearn: assert property (p_relearn) else $error("no relearn after fault clears");

	property p_defaults;
		!$past(RESET_N) |-> (q.cfg.tgt_max == `RST_TGT_MAX) && (q.cfg.tgt_min == `RST_TGT_MIN);
	endproperty
	a_defaults: assert property (p_defaults) else $error("target limits not at defaults");

	property p_limit_sign;
		!q.cfg.tgt_max[`TGT_W-1] && (q.cfg.tgt_min[`TGT_W-1] || (q.cfg.tgt_min == '0));
	endproperty
	a_limit_sign: assert property (p_limit_sign) else $error("target limit of wrong sign");

	property p_safe_hold;
		(q.run == ST_NEUTRAL && !(scl.valid && scl.neutral)) |=> !MOTOR_ENERGIZE && q.ssv;
	endproperty
	a_safe_hold: assert property (p_safe_hold) else $error("motor on before neutral");

	property p_ssv_off;
		q.ssv |-> !MOTOR_ENERGIZE && !MOTOR_MOVE;
	endproperty
	a_ssv_off: assert property (p_ssv_off) else $error("energized during violation");

	property p_no_safe;
		(q.run == ST_WAIT && resume && pwr_s && q.no_safe && !err_s && !q.err_prev)
			|=> (q.run == ST_RUN) && MOTOR_ENERGIZE;
	endproperty
	a_no_safe: assert property (p_no_safe) else $error("safe start not bypassed");

	property p_resume_gate;
		(q.run == ST_WAIT && !(resume && pwr_s)) |=> !MOTOR_ENERGIZE;
	endproperty
	a_resume_gate: assert property (p_resume_gate) else $error("motion without resume");

	property p_dir_inv;
		(q.move && q.mode == MODE_APOS && (q.tgt_out > q.pos)) |-> (MOTOR_DIR == !q.inv_mot);
	endproperty
	a_dir_inv: assert property (p_dir_inv) else $error("direction inversion wrong");

	property p_scl_speed;
		(q.mode == MODE_ASPD) |-> SCL_OE && SCL_O;
	endproperty
	a_scl_speed: assert property (p_scl_speed) else $error("scl not driven in speed mode");

	property p_refuse_max;
		(wr && (PADDR == `OFF_TGT_MAX) && PWDATA[`TGT_W-1])
			|=> (q.cfg.tgt_max == $past(q.cfg.tgt_max));
	endproperty
	a_refuse_max: assert property (p_refuse_max) else $error("negative maximum accepted");

	property p_refuse_min;
		(wr && (PADDR == `OFF_TGT_MIN) && !PWDATA[`TGT_W-1] && (PWDATA != '0))
			|=> (q.cfg.tgt_min == $past(q.cfg.tgt_min));
	endproperty
	a_refuse_min: assert property (p_refuse_min) else $error("positive minimum accepted");

	property p_ssv_flag;
		(q.run == ST_WAIT && resume && pwr_s && (q.mode == MODE_ASPD) && !q.no_safe
			&& !err_s && !q.err_prev && (PWDATA[`CTRL_MODE_LSB +: 2] == q.mode))
			|=> q.ssv && q.status[`EV_SSV];
	endproperty
	a_ssv_flag: assert property (p_ssv_flag) else $error("violation not reported");

	property p_status_sticky;
		!(rd && (PADDR == `OFF_STATUS)) |=> ((q.status & $past(q.status)) == $past(q.status));
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

	property p_neutral_zero;
		(scl.valid && scl.neutral) |=> (MOTOR_TARGET == '0);
	endproperty
	a_neutral_zero: assert property (p_neutral_zero) else $error("neutral input not zero");

	property p_speed_dir;
		(q.move && (q.mode == MODE_ASPD)) |-> (MOTOR_DIR == (!MOTOR_TARGET[`TGT_W-1] ^ q.inv_mot));
	endproperty
	a_speed_dir: assert property (p_speed_dir) else $error("speed direction wrong");
endmodule

// *** logic/aims_params.svh ***
// Purpose: named constants for the analog input motion scaling block
// Assumes: 8-bit byte addresses on APB, one aligned 32-bit word per register
// Notes: identity-free; all offsets, control and status field positions and reset values live here
`ifndef AIMS_PARAMS_SVH
`define AIMS_PARAMS_SVH

// widths
`define ADC_W          12
`define TGT_W          32
`define FRAC_W         16
`define EV_W           4

// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_IN_MAX     8'h04
`define OFF_NEU_MAX    8'h08
`define OFF_NEU_MIN    8'h0C
`define OFF_IN_MIN     8'h10
`define OFF_TGT_MAX    8'h14
`define OFF_TGT_MIN    8'h18
`define OFF_DEGREE     8'h1C
`define OFF_STATUS     8'h20
`define OFF_MASK       8'h24
`define OFF_STATE      8'h28
`define OFF_TARGET     8'h2C
`define OFF_POSITION   8'h30

// control register fields
`define CTRL_MODE_LSB  0
`define CTRL_NOSAFE    2
`define CTRL_INV_IN    3
`define CTRL_INV_MOT   4
`define CTRL_MICRO     5
`define CTRL_RESUME    8

// status event bits
`define EV_LEARN       0
`define EV_SSV         1
`define EV_ERR         2
`define EV_RESUME      3

// reset values and the scaler's fixed-point one
`define RST_IN_MAX     12'hFFF
`define RST_NEU_MAX    12'h820
`define RST_NEU_MIN    12'h7E0
`define RST_IN_MIN     12'h000
`define RST_TGT_MAX    32'h000000C8
`define RST_TGT_MIN    32'hFFFFFF38
`define RST_DEGREE     2'h1
`define FRAC_ONE       17'h10000

`endif

// *** logic/aims_pkg.sv ***
// Purpose: types shared by the analog input motion scaling block
// Assumes: constants come from aims_params.svh
// Notes: the state of aims_core and aims_scaler is held in these packed structs
package aims_pkg;
	`include "aims_params.svh"

	typedef enum logic [1:0] {
		MODE_OFF  = 2'b00,
		MODE_APOS = 2'b01,
		MODE_ASPD = 2'b10,
		MODE_RSVD = 2'b11
	} mode_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_LEARN   = 3'b001,
		ST_WAIT    = 3'b010,
		ST_NEUTRAL = 3'b011,
		ST_RUN     = 3'b100
	} run_t;

	typedef struct packed {
		logic [`ADC_W-1:0]        in_max;
		logic [`ADC_W-1:0]        in_neu_max;
		logic [`ADC_W-1:0]        in_neu_min;
		logic [`ADC_W-1:0]        in_min;
		logic signed [`TGT_W-1:0] tgt_max;
		logic signed [`TGT_W-1:0] tgt_min;
		logic [1:0]               degree;
		logic                     inv_in;
	} scale_cfg_t;

	typedef struct packed {
		logic signed [`TGT_W-1:0] target;
		logic                     neutral;
		logic                     valid;
	} scl_state_t;

	typedef struct packed {
		mode_t                    mode;
		logic                     no_safe;
		logic                     inv_mot;
		logic                     micro;
		scale_cfg_t               cfg;
		logic [`EV_W-1:0]         status;
		logic [`EV_W-1:0]         mask;
		run_t                     run;
		logic                     known;
		logic signed [`TGT_W-1:0] pos;
		logic signed [`TGT_W-1:0] tgt_out;
		logic                     dir_log;
		logic                     dir_phys;
		logic                     move;
		logic                     energize;
		logic                     ssv;
		logic                     err_prev;
		logic [31:0]              rdata;
		logic                     slverr;
	} core_t;
endpackage

// *** logic/aims_scaler.sv ***
// Purpose: maps an analog sample onto a signed target through the calibration
// Assumes: sample arrives with a one-cycle valid on the system clock
// Notes: result is registered one cycle after the sample
`timescale 1ns/10ps
`include "aims_params.svh"
module aims_scaler
	import aims_pkg::*;
(
	input  wire logic                   clock,    // system clock
	input  wire logic                   reset_n,  // synchronous reset, active low
	input  aims_pkg::scale_cfg_t        cfg,      // calibration settings
	input  wire logic [`ADC_W-1:0]      sample,   // raw analog code
	input  wire logic                   smp_vld,  // sample strobe
	output aims_pkg::scl_state_t        res       // target, neutral flag, valid
);
	scl_state_t q;
	scl_state_t d;

	// piecewise scaling with dead band, saturation and degree shaping
	always_comb begin
		logic                  up;
		logic                  dn;
		logic                  pos_side;
		logic [`ADC_W-1:0]     num;
		logic [`ADC_W-1:0]     den;
		logic [27:0]           quo;
		logic [16:0]           frac;
		logic [33:0]           sq;
		logic [33:0]           cu;
		logic [16:0]           fd;
		logic signed [17:0]    sfd;
		logic signed [`TGT_W-1:0] lim;
		logic signed [49:0]    prod;
		d = q;
		up       = 1'b0;
		dn       = 1'b0;
		pos_side = 1'b0;
		quo      = '0;
		frac     = '0;
		sq       = '0;
		cu       = '0;
		fd       = '0;
		sfd      = '0;
		lim      = '0;
		prod     = '0;
		up = sample > cfg.in_neu_max;
		dn = sample < cfg.in_neu_min;
		num = '0;
		den = '0;
		if (up) begin
			num = ((sample > cfg.in_max) ? cfg.in_max : sample) - cfg.in_neu_max;
			den = cfg.in_max - cfg.in_neu_max;
		end else if (dn) begin
			num = cfg.in_neu_min - ((sample < cfg.in_min) ? cfg.in_min : sample);
			den = cfg.in_neu_min - cfg.in_min;
		end
		quo = (den == '0) ? 28'h0010000 : ({num, 16'h0000} / {16'h0000, den});
		frac = (quo > 28'h0010000) ? `FRAC_ONE : quo[16:0];
		sq = frac * frac;
		cu = sq[32:16] * frac;
		// degree 0 and 1 are linear, higher degrees flatten the neutral region
		case (cfg.degree)
			2'h2:    fd = sq[32:16];
			2'h3:    fd = cu[32:16];
			default: fd = frac;
		endcase
		pos_side = up ^ cfg.inv_in;
		lim = pos_side ? cfg.tgt_max : cfg.tgt_min;
		sfd = $signed({1'b0, fd});
		prod = sfd * lim;
		d.valid = smp_vld;
		if (smp_vld) begin
			d.neutral = !up && !dn;
			d.target = (up || dn) ? prod[47:16] : '0;
		end
	end

	// result register
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign res = q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	property p_dead_band;
		(q.valid && q.neutral) |-> (q.target == '0);
	endproperty
	a_dead_band: assert property (p_dead_band) else $error("neutral sample gave nonzero target");
endmodule

// *** logic/aims_sync.sv ***
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, not pulses
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
module aims_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,   // system clock
	input  wire logic         reset_n, // synchronous reset, active low
	input  wire logic [W-1:0] async_i, // level from a pin
	output logic      [W-1:0] sync_o   // level safe to use
);
	logic [1:0][W-1:0] stg_q;
	logic [1:0][W-1:0] stg_d;

	// shift the pin level through two stages
	always_comb begin
		stg_d[0] = async_i;
		stg_d[1] = stg_q[0];
	end

	// stage registers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			stg_q <= '0;
		end else begin
			stg_q <= stg_d;
		end
	end

	assign sync_o = stg_q[1];
endmodule

// *** tb/aims_core_tb.sv ***
// Purpose: self-checking bench for the analog motion front end
// Assumes: zero-wait APB, calibration left at its reset values
// Notes: expected targets come from a bench copy of the scaling law
`timescale 1ns/10ps
`include "aims_params.svh"
module aims_core_tb;
	import aims_pkg::*;
	logic        CLOCK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [11:0] code, wiper;
	logic        valid, pwr, flt, step, scl_o, scl_oe, ener, dir, move, micro, irq, er;
	logic signed [31:0] tgt;
	int          fails, num_checks, cyc, seed;
	logic [7:0]  ra [7] = '{`OFF_IN_MAX, `OFF_NEU_MAX, `OFF_NEU_MIN, `OFF_IN_MIN,
		`OFF_TGT_MAX, `OFF_TGT_MIN, `OFF_DEGREE};
	logic [31:0] rv [7] = '{`RST_IN_MAX, `RST_NEU_MAX, `RST_NEU_MIN, `RST_IN_MIN,
		`RST_TGT_MAX, `RST_TGT_MIN, `RST_DEGREE};
	logic [11:0] wl [8] = '{12'h000, 12'h7E0, 12'h820, 12'hFFF, 12'h0, 12'h0, 12'h0, 12'h800};

	aims_core u_aims_core (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .ANALOG_INPUT_PIN_CODE(code), .ANALOG_INPUT_PIN_VALID(valid),
		.MOTOR_POWER(pwr), .DRIVER_FAULT(flt), .STEP_DONE(step), .SCL_I(scl_o & scl_oe),
		.SCL_O(scl_o), .SCL_OE(scl_oe), .MOTOR_ENERGIZE(ener), .MOTOR_DIR(dir),
		.MOTOR_MOVE(move), .MOTOR_TARGET(tgt), .MOTOR_MICRO(micro), .IRQ(irq));
	aims_pot_model u_aims_pot_model (.clock(CLOCK), .reset_n(RESET_N),
		.supply(scl_o & scl_oe), .wiper(wiper), .code(code), .valid(valid));

	// free-running clock, 20 ns period
	initial begin
		CLOCK = 1'b0;
		forever #10 CLOCK = ~CLOCK;
	end
	// hang guard
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end
	// scaling law with reset calibration: dead band, linear, squared or cubed
	function automatic longint scl(longint x, int deg, bit inv);
		longint f;
		longint g;
		longint lim;
		if (x >= `RST_NEU_MIN && x <= `RST_NEU_MAX)
			return 0;
		if (x > `RST_NEU_MAX)
			f = (x - `RST_NEU_MAX) * 65536 / (`RST_IN_MAX - `RST_NEU_MAX);
		else
			f = (`RST_NEU_MIN - x) * 65536 / (`RST_NEU_MIN - `RST_IN_MIN);
		lim = ((x > `RST_NEU_MAX) ^ inv) ? 200 : -200;
		g = f;
		if (deg >= 2)
			g = g * f / 65536;
		if (deg == 3)
			g = g * f / 65536;
		return (g * lim) >>> 16;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// poll the sequencer state code
	task automatic wst(input logic [2:0] s);
		int n;
		n = 0;
		do begin
			apb(1'b0, `OFF_STATE, 32'h0);
			n++;
		end while (rd[2:0] !== s && n < 60);
		chk(rd[2:0], s);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge CLOCK);
	endtask

	// main sequence
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, pwr, flt, step} = '0;
		RESET_N = 1'b0;
		wiper = 12'hFFF;
		seed = 32'h4f2e;
		pause(16);
		RESET_N <= 1'b1;
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		apb(1'b1, `OFF_TGT_MAX, 32'h80000000);
		chk(er, 1'b1);
		apb(1'b1, `OFF_TGT_MIN, 32'h5);
		chk(er, 1'b1);
		apb(1'b0, `OFF_TGT_MIN, 32'h0);
		chk(rd, `RST_TGT_MIN);
		apb(1'b0, 8'h3C, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, `OFF_MASK, 32'h4);
		apb(1'b1, `OFF_CTRL, 32'h31);
		pause(1);
		chk({scl_o, scl_oe, micro}, 3'b111);
		wst(ST_WAIT);
		apb(1'b0, `OFF_POSITION, 32'h0);
		chk(rd, 32'd200);
		apb(1'b1, `OFF_CTRL, 32'h131);
		pause(4);
		wst(ST_WAIT);
		pwr <= 1'b1;
		pause(4);
		apb(1'b1, `OFF_CTRL, 32'h131);
		wst(ST_RUN);
		chk(ener, 1'b1);
		foreach (wl[i]) begin
			wiper <= (i > 3 && i < 7) ? 12'($random(seed)) : wl[i];
			pause(40);
			chk(tgt, 32'(scl(wiper, 1, 0)));
		end
		chk({move, dir}, 2'b11);
		step <= 1'b1;
		@(posedge CLOCK);
		step <= 1'b0;
		apb(1'b0, `OFF_POSITION, 32'h0);
		chk(rd, 32'd199);
		flt <= 1'b1;
		wiper <= 12'hFFF;
		pause(8);
		chk(irq, 1'b1);
		flt <= 1'b0;
		wst(ST_WAIT);
		apb(1'b0, `OFF_POSITION, 32'h0);
		chk(rd, 32'd200);
		apb(1'b0, `OFF_STATUS, 32'h0);
		chk(rd[2], 1'b1);
		pause(1);
		chk(irq, 1'b0);
		apb(1'b1, `OFF_CTRL, 32'h2);
		wst(ST_WAIT);
		apb(1'b1, `OFF_CTRL, 32'h102);
		wst(ST_NEUTRAL);
		apb(1'b0, `OFF_STATE, 32'h0);
		chk({rd[5], ener}, 2'b10);
		wiper <= 12'h800;
		wst(ST_RUN);
		chk(tgt, 32'h0);
		wiper <= 12'h000;
		pause(40);
		chk(tgt, 32'(-200));
		apb(1'b1, `OFF_CTRL, 32'h0);
		apb(1'b1, `OFF_DEGREE, 32'h2);
		wiper <= 12'hC00;
		apb(1'b1, `OFF_CTRL, 32'hE);
		wst(ST_WAIT);
		apb(1'b1, `OFF_CTRL, 32'h10E);
		wst(ST_RUN);
		pause(40);
		chk(tgt, 32'(scl(12'hC00, 2, 1)));
		apb(1'b1, `OFF_DEGREE, 32'h3);
		pause(40);
		chk(tgt, 32'(scl(12'hC00, 3, 1)));
		wrap_up();
	end
endmodule

// *** tb/aims_pot_model.sv ***
// Purpose: analog source on the far side of the converter input
// Assumes: the bench sets the wiper code; the source is fed from SCL
// Notes: unpowered, the wiper floats, shown as a code that flips each cycle
`timescale 1ns/10ps
`include "aims_params.svh"
module aims_pot_model (
	input  wire logic              clock,   // system clock
	input  wire logic              reset_n, // synchronous reset, active low
	input  wire logic              supply,  // level on the SCL pin
	input  wire logic [`ADC_W-1:0] wiper,   // wiper code while powered
	output logic      [`ADC_W-1:0] code,    // code on the analog input pin
	output logic                   valid    // one-cycle sample strobe
);
	logic [3:0] cnt_q;
	// one sample every 16 cycles, wiper voltage on the analog pin
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			cnt_q <= 4'h0;
			valid <= 1'b0;
			code  <= 12'h000;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			valid <= (cnt_q == 4'hF);
			code  <= supply ? wiper : ~code;
		end
	end
endmodule
